// ==== hw/wdss_top.sv ====
// The address map and the Wishbone register port were left to the implementer.
module wdss_top
  import wdss_pkg::*;
#(
  parameter int WD_BASE = WD_BASE_EXP,
  parameter int POR_LEN = POR_CYCLES,
  parameter int WD_DLY = WD_RST_DELAY
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // supply comparators
  input wire logic below_reset_i,
  input wire logic below_warning_i,
  // processor side
  output logic cpu_reset_o,
  output logic [15:0] cpu_start_addr_o,
  output logic supply_warning_interrupt_o,
  output logic [15:0] irq_vector_o,
  output logic irq_o,
  // reset pin
  output logic rst_pin_o,
  output logic rst_pin_oe_o
);

  // ----------------------------------------------------------------
  // widths and state
  // ----------------------------------------------------------------
  localparam int WD_W = WD_BASE + 3 * WD_STEP_EXP + 1;
  localparam int SEQ_W = $clog2(POR_LEN + 1);
  localparam int DLY_W = $clog2(WD_DLY + 1);

  wdss_state_e state;
  wdss_state_e next_state;
  logic [SEQ_W-1:0] seq_cnt;
  logic [SEQ_W-1:0] next_seq_cnt;
  logic below_rst_s;
  logic below_warn_s;
  logic below_warn_d;
  logic init;

  // supervisor_control bits
  logic por_flag;
  logic supply_warning_enable;
  logic supply_warning_flag;
  logic timeout_warning_flag;
  logic timeout_reset_flag;
  logic reset_on_timeout_enable;
  // other control
  logic [1:0] timeout_select;
  logic [1:0] clock_divide_select;
  logic double_speed_select;
  logic global_interrupt_enable;
  logic [IRQ_N-1:0] irq_status;
  logic [IRQ_N-1:0] irq_mask;
  logic [IRQ_N-1:0] irq_event;

  // timed access
  logic ta_armed;
  logic ta_open;
  logic [7:0] ta_cnt;

  // watchdog
  logic [WD_W-1:0] wd_cnt;
  logic [DLY_W-1:0] wd_dly;
  logic wd_pend;
  logic wd_expire;
  logic wd_fire;
  logic wd_restart;

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  wdss_tick_if tk ();

  assign tk.double_speed = double_speed_select;
  assign tk.divide_sel = clock_divide_select;

  wdss_prescale u_prescale (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tk(tk.src)
  );

  wdss_sync #(.W(2)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({below_warning_i, below_reset_i}),
    .q_o({below_warn_s, below_rst_s})
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic bus_req;
  logic wr_lane;
  logic hit_supv;
  logic hit_clkc;
  logic hit_pwrm;
  logic hit_irqs;
  logic hit_irqm;
  logic hit_tacc;
  logic hit_ien;
  logic wr_supv;
  logic wr_clkc;
  logic wr_pwrm;
  logic wr_irqs;
  logic wr_irqm;
  logic wr_tacc;
  logic wr_ien;
  logic [7:0] wdat;
  logic [7:0] supv_rd;
  logic [31:0] rd_data;

  assign bus_req = wb_cyc_i & wb_stb_i;
  // a write lands on the edge where the master sees ack
  assign wr_lane = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign wdat = wb_dat_i[7:0];
  assign hit_supv = (wb_adr_i == OFS_SUPV);
  assign hit_clkc = (wb_adr_i == OFS_CLKC);
  assign hit_pwrm = (wb_adr_i == OFS_PWRM);
  assign hit_irqs = (wb_adr_i == OFS_IRQS);
  assign hit_irqm = (wb_adr_i == OFS_IRQM);
  assign hit_tacc = (wb_adr_i == OFS_TACC);
  assign hit_ien = (wb_adr_i == OFS_IEN);
  assign wr_supv = wr_lane & hit_supv;
  assign wr_clkc = wr_lane & hit_clkc;
  assign wr_pwrm = wr_lane & hit_pwrm;
  assign wr_irqs = wr_lane & hit_irqs;
  assign wr_irqm = wr_lane & hit_irqm;
  assign wr_tacc = wr_lane & hit_tacc;
  assign wr_ien = wr_lane & hit_ien;

  always_comb begin
    supv_rd = 8'h00;
    supv_rd[SC_POR] = por_flag;
    supv_rd[SC_SWEN] = supply_warning_enable;
    supv_rd[SC_SWFL] = supply_warning_flag;
    supv_rd[SC_WARN] = timeout_warning_flag;
    supv_rd[SC_WRST] = timeout_reset_flag;
    supv_rd[SC_RTOE] = reset_on_timeout_enable;
  end

  // unmapped addresses and the timed access register read as zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit_supv) begin
      rd_data[7:0] = supv_rd;
    end else if (hit_clkc) begin
      rd_data[CK_TSEL_LO +: 2] = timeout_select;
    end else if (hit_pwrm) begin
      rd_data[PM_CDIV_LO +: 2] = clock_divide_select;
      rd_data[PM_DSPD] = double_speed_select;
    end else if (hit_irqs) begin
      rd_data[IRQ_N-1:0] = irq_status;
    end else if (hit_irqm) begin
      rd_data[IRQ_N-1:0] = irq_mask;
    end else if (hit_ien) begin
      rd_data[IE_GIE] = global_interrupt_enable;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      wb_dat_o <= rd_data;
    end
  end

  // ----------------------------------------------------------------
  // timed access
  // ----------------------------------------------------------------
  // key1 then key2 opens a short window for one protected write
  always_ff @(posedge clk_i) begin
    if (init) begin
      ta_armed <= 1'b0;
      ta_open <= 1'b0;
      ta_cnt <= 8'h00;
    end else if (wr_tacc) begin
      ta_armed <= (wdat == TA_KEY1);
      ta_open <= ta_armed & (wdat == TA_KEY2);
      ta_cnt <= 8'h00;
    end else if (wr_supv || ta_cnt == TA_WINDOW) begin
      ta_armed <= 1'b0;
      ta_open <= 1'b0;
    end else if (ta_armed || ta_open) begin
      ta_cnt <= ta_cnt + 8'h01;
    end
  end

  assign wd_restart = wr_supv & ta_open & wdat[SC_RSTRT];

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // a supply-fail hold reinitialises the timed-access, control, flag, watchdog and interrupt registers, as a power-on would
  assign init = rst_i | (state == ST_HOLD);

  always_ff @(posedge clk_i) begin
    if (init) begin
      por_flag <= 1'b1;
      supply_warning_enable <= 1'b0;
      reset_on_timeout_enable <= RTOE_RST;
      timeout_select <= TSEL_RST;
      clock_divide_select <= CDIV_RST;
      double_speed_select <= DSPD_RST;
      global_interrupt_enable <= GIE_RST;
      irq_mask <= '0;
    end else begin
      if (wr_supv) begin
        por_flag <= por_flag & wdat[SC_POR];
        supply_warning_enable <= wdat[SC_SWEN];
      end
      if (wr_supv && ta_open) begin
        reset_on_timeout_enable <= wdat[SC_RTOE];
      end
      if (wr_clkc) begin
        timeout_select <= wdat[CK_TSEL_LO +: 2];
      end
      if (wr_pwrm) begin
        clock_divide_select <= wdat[PM_CDIV_LO +: 2];
        double_speed_select <= wdat[PM_DSPD];
      end
      if (wr_ien) begin
        global_interrupt_enable <= wdat[IE_GIE];
      end
      if (wr_irqm) begin
        irq_mask <= wdat[IRQ_N-1:0];
      end
    end
  end

  // hardware flags: software clears by writing zero, a set wins
  always_ff @(posedge clk_i) begin
    if (init) begin
      supply_warning_flag <= 1'b0;
      timeout_warning_flag <= 1'b0;
      timeout_reset_flag <= 1'b0;
    end else begin
      supply_warning_flag <= below_warn_s |
        (supply_warning_flag & ~(wr_supv & ~wdat[SC_SWFL]));
      timeout_warning_flag <= wd_expire |
        (timeout_warning_flag & ~(wr_supv & ~wdat[SC_WARN]));
      timeout_reset_flag <= wd_fire |
        (timeout_reset_flag & ~(wr_supv & ~wdat[SC_WRST]));
    end
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  function automatic logic [WD_W-1:0] wd_limit(input logic [1:0] sel);
    wd_limit = WD_W'(1) << (WD_BASE + WD_STEP_EXP * int'(sel));
  endfunction

  assign wd_expire = tk.tick &
    (wd_cnt == wd_limit(timeout_select) - WD_W'(1));
  assign wd_fire = wd_pend & (wd_dly == DLY_W'(WD_DLY - 1));

  // no enable: the counter stops only while the processor is in reset
  always_ff @(posedge clk_i) begin
    if (init || state != ST_RUN || wd_restart) begin
      wd_cnt <= '0;
      wd_pend <= 1'b0;
      wd_dly <= '0;
    end else begin
      if (tk.tick) begin
        wd_cnt <= wd_expire ? '0 : wd_cnt + WD_W'(1);
      end
      if (wd_expire) begin
        wd_pend <= 1'b1;
        wd_dly <= '0;
      end else if (wd_fire) begin
        wd_pend <= 1'b0;
      end else if (wd_pend) begin
        wd_dly <= wd_dly + DLY_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // reset sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_seq_cnt = seq_cnt + SEQ_W'(1);
    case (state)
      ST_HOLD: begin
        next_seq_cnt = '0;
        if (!below_rst_s) begin
          next_state = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (seq_cnt == SEQ_W'(POR_LEN - 1)) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        next_seq_cnt = '0;
        if (wd_fire && reset_on_timeout_enable) begin
          next_state = ST_WDRST;
        end
      end
      ST_WDRST: begin
        if (seq_cnt == SEQ_W'(WDRST_CYCLES - 1)) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_HOLD;
      end
    endcase
    if (below_rst_s) begin
      next_state = ST_HOLD;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_HOLD;
      seq_cnt <= '0;
      below_warn_d <= 1'b0;
    end else begin
      state <= next_state;
      seq_cnt <= next_seq_cnt;
      below_warn_d <= below_warn_s;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  // the timeout warning has no event here; it is only polled
  always_comb begin
    irq_event = '0;
    irq_event[IRQ_SUPPLY] = below_warn_s & ~below_warn_d;
    irq_event[IRQ_WDRST] = wd_fire;
    irq_event[IRQ_PORDONE] = (state == ST_COUNT) &&
      (next_state == ST_RUN);
  end

  always_ff @(posedge clk_i) begin
    if (init) begin
      irq_status <= '0;
    end else begin
      irq_status <= irq_event |
        (irq_status & ~(wr_irqs ? wdat[IRQ_N-1:0] : '0));
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic pfi_req;
  logic irq_any;

  assign pfi_req = supply_warning_enable & supply_warning_flag;
  // supply bit bypasses the global enable, the others need it
  assign irq_any = (irq_status[IRQ_SUPPLY] & irq_mask[IRQ_SUPPLY]) |
    (global_interrupt_enable &
     |(irq_status[IRQ_N-1:1] & irq_mask[IRQ_N-1:1]));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_reset_o <= 1'b1;
      cpu_start_addr_o <= RESET_VECTOR;
      supply_warning_interrupt_o <= 1'b0;
      irq_vector_o <= 16'h0000;
      irq_o <= 1'b0;
      rst_pin_o <= 1'b1;
      rst_pin_oe_o <= 1'b1;
    end else begin
      cpu_reset_o <= (next_state != ST_RUN);
      cpu_start_addr_o <= RESET_VECTOR;
      supply_warning_interrupt_o <= pfi_req;
      irq_vector_o <= pfi_req ? PFI_VECTOR : 16'h0000;
      irq_o <= irq_any;
      // supply-fail hold drives the pin so it can reset other parts
      rst_pin_o <= (next_state == ST_HOLD) ||
        (next_state == ST_COUNT);
      rst_pin_oe_o <= (next_state == ST_HOLD) ||
        (next_state == ST_COUNT);
    end
  end

endmodule // wdss_top

// ==== hw/wdss_pkg.sv ====
package wdss_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SUPV = 8'h00;
  localparam logic [7:0] OFS_CLKC = 8'h04;
  localparam logic [7:0] OFS_PWRM = 8'h08;
  localparam logic [7:0] OFS_IRQS = 8'h0c;
  localparam logic [7:0] OFS_IRQM = 8'h10;
  localparam logic [7:0] OFS_TACC = 8'h14;
  localparam logic [7:0] OFS_IEN = 8'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SC_POR = 6;
  localparam int SC_SWEN = 5;
  localparam int SC_SWFL = 4;
  localparam int SC_WARN = 3;
  localparam int SC_WRST = 2;
  localparam int SC_RTOE = 1;
  localparam int SC_RSTRT = 0;
  localparam int CK_TSEL_LO = 6;
  localparam int PM_CDIV_LO = 6;
  localparam int PM_DSPD = 3;
  localparam int IE_GIE = 7;
  localparam int IRQ_SUPPLY = 0;
  localparam int IRQ_WDRST = 1;
  localparam int IRQ_PORDONE = 2;
  localparam int IRQ_N = 3;

  // ----------------------------------------------------------------
  // reset values and keys
  // ----------------------------------------------------------------
  localparam logic [1:0] TSEL_RST = 2'h0;
  localparam logic [1:0] CDIV_RST = 2'h2;
  localparam logic DSPD_RST = 1'h1;
  localparam logic RTOE_RST = 1'h0;
  localparam logic GIE_RST = 1'h0;
  localparam logic [7:0] TA_KEY1 = 8'haa;
  localparam logic [7:0] TA_KEY2 = 8'h55;
  localparam logic [7:0] TA_WINDOW = 8'h20;
  localparam logic [15:0] PFI_VECTOR = 16'h0033;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // ----------------------------------------------------------------
  // timing in clock cycles; the watchdog timeouts as log2 of prescaler ticks
  // ----------------------------------------------------------------
  localparam int WD_BASE_EXP = 15;
  localparam int WD_STEP_EXP = 3;
  localparam int WD_RST_DELAY = 512;
  localparam int POR_CYCLES = 65536;
  localparam int WDRST_CYCLES = 16;
  localparam logic [10:0] DIV_FAST = 11'h001;
  localparam logic [10:0] DIV_NORM = 11'h002;
  localparam logic [10:0] DIV_MID = 11'h004;
  localparam logic [10:0] DIV_SLOW = 11'h400;

  typedef enum logic [3:0] {
    ST_HOLD = 4'b0001,
    ST_COUNT = 4'b0010,
    ST_RUN = 4'b0100,
    ST_WDRST = 4'b1000
  } wdss_state_e;

endpackage

// ==== hw/wdss_tick_if.sv ====
interface wdss_tick_if;
  logic double_speed;
  logic [1:0] divide_sel;
  logic tick;
  modport src (input double_speed, input divide_sel, output tick);
  modport snk (output double_speed, output divide_sel, input tick);
endinterface

// ==== hw/wdss_sync.sv ====
module wdss_sync #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule // wdss_sync

// ==== hw/wdss_prescale.sv ====
module wdss_prescale
  import wdss_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // rate select and tick
  wdss_tick_if.src tk
);
  logic [10:0] cnt;
  logic [10:0] ratio;

  // system clock rate relative to the oscillator
  assign ratio = (tk.divide_sel == 2'h3) ? DIV_SLOW :
                 (tk.divide_sel != 2'h0) ? DIV_MID :
                 tk.double_speed ? DIV_FAST : DIV_NORM;

  // >= so that a smaller ratio picked mid-count does not run away
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
      tk.tick <= 1'b0;
    end else if (cnt >= ratio - 11'h001) begin
      cnt <= '0;
      tk.tick <= 1'b1;
    end else begin
      cnt <= cnt + 11'h001;
      tk.tick <= 1'b0;
    end
  end
endmodule // wdss_prescale

// ==== testbench/wdss_top_sva.sv ====
module wdss_top_sva
  import wdss_pkg::*;
#(
  parameter int POR_LEN = 65536
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // supply and processor
  input wire logic below_reset_i,
  input wire logic cpu_reset_o,
  input wire logic [15:0] cpu_start_addr_o,
  input wire logic supply_warning_interrupt_o,
  input wire logic [15:0] irq_vector_o,
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // --------------------------------------------------------------
  // cycles since the supply last sat below the reset threshold
  // --------------------------------------------------------------
  int low_cnt;

  always_ff @(posedge clk_i) begin
    if (rst_i || below_reset_i) begin
      low_cnt <= 0;
    end else if (low_cnt < POR_LEN + 10) begin
      low_cnt <= low_cnt + 1;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o)
    else $error("request not answered next cycle");
  AST_LOW_SUPPLY: assert property (below_reset_i [*6] |-> cpu_reset_o)
    else $error("low supply not holding the processor");
  AST_PIN_OE: assert property (rst_pin_o == rst_pin_oe_o)
    else $error("reset pin level and enable disagree");
  AST_PIN_RST: assert property (rst_pin_o |-> cpu_reset_o)
    else $error("reset pin driven without processor reset");
  AST_POR_LEN: assert property ($fell(rst_pin_o) |->
    low_cnt inside {[POR_LEN:POR_LEN + 8]})
    else $error("power-on hold length wrong");
  AST_START: assert property (cpu_start_addr_o == RESET_VECTOR)
    else $error("start address not zero");
  AST_VEC_ON: assert property (supply_warning_interrupt_o |->
    irq_vector_o == PFI_VECTOR)
    else $error("supply warning vector wrong");
  AST_VEC_OFF: assert property (!supply_warning_interrupt_o |->
    irq_vector_o == 16'h0000)
    else $error("vector without supply warning");
  AST_WD_HOLD: assert property ($rose(cpu_reset_o) && !rst_pin_o |=>
    cpu_reset_o [*8])
    else $error("timeout reset too short");
endmodule // wdss_top_sva

bind wdss_top wdss_top_sva #(.POR_LEN(POR_LEN)) wdss_top_sva_inst (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .below_reset_i,
  .cpu_reset_o, .cpu_start_addr_o, .supply_warning_interrupt_o,
  .irq_vector_o, .rst_pin_o, .rst_pin_oe_o
);

// ==== testbench/wdss_cpu_model.sv ====
module wdss_cpu_model (
  // clock
  input wire logic clk_i,
  // wishbone master
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [31:0] dat_o,
  output logic [3:0] sel_o,
  input wire logic [31:0] dat_i,
  input wire logic ack_i
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    dat_o = 32'h00000000;
    sel_o = 4'hf;
  end

  // one classic cycle; afterwards address and data show the inverse of the last value, we and sel keep theirs
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= {24'h000000, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i[7:0];
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~dat_o;
  endtask
endmodule // wdss_cpu_model

// ==== testbench/wdss_top_tb.sv ====
module wdss_top_tb
  import wdss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PL = 16;
  localparam int WDLY = 8;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic bl_rst = 1'b0;
  logic bl_warn = 1'b0;
  logic cyc, stb, we, ack, crst, swi, irq, pin, pin_oe;
  logic [7:0] adr, q, d;
  logic [31:0] wdat, rdat;
  logic [3:0] sel;
  logic [15:0] start, vec;
  logic [7:0] ra[4] = '{OFS_CLKC, OFS_PWRM, OFS_IRQM, OFS_IEN};
  logic [7:0] rm[4] = '{8'hc0, 8'hc8, 8'h07, 8'h80};
  logic [7:0] pm[4] = '{8'h00, 8'h40, 8'h80, 8'hc0};
  int dv[4] = '{2, 4, 4, 1024};
  int mdl[4];
  int bad_count = 0;
  int num_checks = 0;
  int cyc_n = 0;
  int t0, k;
  bit rst_seen;

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc_n <= cyc_n + 1;
  always @(posedge clk_i) if (crst === 1'b1) rst_seen <= 1'b1;

  wdss_top #(.WD_BASE(4), .POR_LEN(PL), .WD_DLY(WDLY)) wdss_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_dat_o(rdat), .wb_ack_o(ack), .below_reset_i(bl_rst),
    .below_warning_i(bl_warn), .cpu_reset_o(crst),
    .cpu_start_addr_o(start), .supply_warning_interrupt_o(swi),
    .irq_vector_o(vec), .irq_o(irq), .rst_pin_o(pin),
    .rst_pin_oe_o(pin_oe));
  wdss_cpu_model wdss_cpu_model_inst (
    .clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .dat_o(wdat), .sel_o(sel), .dat_i(rdat), .ack_i(ack));

  // --------------------------------------------------------------
  // checks and bus helpers
  // --------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    wdss_cpu_model_inst.xfer(1'b1, a, v, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    wdss_cpu_model_inst.xfer(1'b0, a, 8'h00, q);
    chk({8'h00, q & m}, {8'h00, e});
  endtask
  task automatic restart(input logic en);
    wr(OFS_TACC, TA_KEY1);
    wr(OFS_TACC, TA_KEY2);
    wr(OFS_SUPV, {6'h00, en, 1'b1});
    t0 = cyc_n;
  endtask
  task automatic wait_rst(input logic v, input int lim);
    while (crst !== v && cyc_n - t0 < lim) @(posedge clk_i);
  endtask
  // warning latency, then the reset flag a fixed delay later
  task automatic wd_time(input int n, input int div);
    restart(1'b0);
    wr(OFS_IRQS, 8'h07);
    q = 8'h00;
    while (q[SC_WARN] !== 1'b1 && cyc_n - t0 < 20000) begin
      wdss_cpu_model_inst.xfer(1'b0, OFS_SUPV, 8'h00, q);
    end
    chk_rng(cyc_n - t0, n * div - div, n * div + 12);
    chk({15'h0000, irq}, 16'h0000);
    repeat (WDLY + 2) @(posedge clk_i);
    rd(OFS_SUPV, 8'h0e, 8'h0c);
    chk({15'h0000, irq}, 16'h0001);
    chk({15'h0000, crst}, 16'h0000);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    bad_count++;
    conclude();
  end

  // --------------------------------------------------------------
  // stimulus
  // --------------------------------------------------------------
  initial begin
    void'($urandom(5507));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t0 = cyc_n;
    wait_rst(1'b0, 200);
    rd(OFS_SUPV, 8'hff, 8'h40);
    rd(OFS_CLKC, 8'hff, {TSEL_RST, 6'h00});
    rd(OFS_PWRM, 8'hff, {CDIV_RST, 2'h0, DSPD_RST, 3'h0});
    rd(OFS_IRQS, 8'hff, 8'h04);
    rd(OFS_IRQM, 8'hff, 8'h00);
    rd(OFS_IEN, 8'hff, {GIE_RST, 7'h00});
    rd(8'h1c, 8'hff, 8'h00);
    wr(OFS_SUPV, 8'h02);
    rd(OFS_SUPV, 8'h42, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 16; i++) begin
      k = $urandom % 4;
      d = 8'($urandom);
      wr(ra[k], d);
      mdl[k] = d & rm[k];
      rd(ra[k], 8'hff, mdl[k][7:0]);
    end
    $display("test random registers done");
    wr(OFS_PWRM, 8'h08);
    // only the reset-flag event may raise irq while the watchdog runs
    wr(OFS_IEN, 8'h80);
    wr(OFS_IRQM, 8'h06);
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CLKC, 8'(s << 6));
      wd_time(1 << (4 + 3 * s), 1);
    end
    wr(OFS_CLKC, 8'h00);
    for (int j = 0; j < 4; j++) begin
      wr(OFS_PWRM, pm[j]);
      wd_time(16, dv[j]);
    end
    wr(OFS_PWRM, 8'h08);
    restart(1'b1);
    wait_rst(1'b1, 200);
    chk_rng(cyc_n - t0, 16 + WDLY - 4, 16 + WDLY + 4);
    wait_rst(1'b0, 300);
    wr(OFS_CLKC, 8'h40);
    restart(1'b1);
    rst_seen = 1'b0;
    repeat (6) begin
      repeat (100) @(posedge clk_i);
      restart(1'b1);
    end
    chk({15'h0000, rst_seen}, 16'h0000);
    restart(1'b0);
    $display("test watchdog done");
    wr(OFS_CLKC, 8'hc0);
    wr(OFS_IEN, 8'h00);
    wr(OFS_IRQM, 8'h00);
    wr(OFS_IRQS, 8'h07);
    wr(OFS_SUPV, 8'h20);
    bl_warn <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk({15'h0000, swi}, 16'h0001);
    chk(vec, PFI_VECTOR);
    chk({15'h0000, irq}, 16'h0000);
    rd(OFS_SUPV, 8'hf3, 8'h30);
    wr(OFS_IRQM, 8'h01);
    repeat (2) @(posedge clk_i);
    chk({15'h0000, irq}, 16'h0001);
    bl_warn <= 1'b0;
    repeat (6) @(posedge clk_i);
    wr(OFS_SUPV, 8'h20);
    wr(OFS_IRQS, 8'h01);
    repeat (2) @(posedge clk_i);
    chk({14'h0000, swi, irq}, 16'h0000);
    wr(OFS_SUPV, 8'h00);
    bl_warn <= 1'b1;
    repeat (8) @(posedge clk_i);
    rd(OFS_SUPV, 8'hf3, 8'h10);
    chk({15'h0000, swi}, 16'h0000);
    bl_warn <= 1'b0;
    $display("test supply warning done");
    bl_rst <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk({13'h0000, crst, pin, pin_oe}, 16'h0007);
    bl_rst <= 1'b0;
    t0 = cyc_n;
    wait_rst(1'b0, 200);
    chk_rng(cyc_n - t0, PL, PL + 8);
    chk(start, RESET_VECTOR);
    rd(OFS_SUPV, 8'hff, 8'h40);
    rd(OFS_CLKC, 8'hff, 8'h00);
    $display("test supply reset done");
    conclude();
  end
endmodule // wdss_top_tb
